// file: verilog/io_memory_access_ordering.sv
// Ordering gate between the load/store unit and the memory system.
// Assumes the memory system pulses doneValid with the tag of each access
// once it is globally visible, and that region registers are set by software.
// ****************************************
// Functional notes
// ****************************************
`timescale 1ns/100ps
`default_nettype none
module io_memory_access_ordering (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset,
	// Core requests
	input  wire logic        reqValid,
	output logic             reqReady,
	input  wire logic [31:0] reqAddr,
	input  wire logic        reqWrite,
	input  wire logic        reqAcquire,
	input  wire logic        reqRelease,
	input  wire logic        reqFence,
	input  wire logic        predIoInput,
	input  wire logic        predIoOutput,
	input  wire logic        predMemRead,
	input  wire logic        predMemWrite,
	input  wire logic        succIoInput,
	input  wire logic        succIoOutput,
	input  wire logic        succMemRead,
	input  wire logic        succMemWrite,
	// Memory side
	output logic             memValid,
	input  wire logic        memReady,
	output logic [31:0]      memAddr,
	output logic             memWrite,
	output logic             memIo,
	output logic             memCacheable,
	output logic             memCoherent,
	output logic [1:0]       memTag,
	input  wire logic        doneValid,
	input  wire logic [1:0]  doneTag,
	// Prefetch check
	input  wire logic [31:0] pfAddr,
	output logic             pfOk,
	// AXI4-Lite slave
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready
);
	localparam int NR = ordering_pkg::NREG;
	localparam int NE = ordering_pkg::NENT;
	localparam int IW = ordering_pkg::IDXW;
	localparam int CW = ordering_pkg::CHW;

	logic [31:0]   base [NR];
	logic [31:0]   mask [NR];
	logic [31:0]   attr [NR];
	logic [31:0]   ctrl;
	logic [15:0]   stallCnt;
	logic [NE-1:0] eV;
	logic [29:0]   eAddr [NE];
	logic          eIo [NE];
	logic          eWr [NE];
	logic          eAcq [NE];
	logic          eStr [NE];
	logic [IW-1:0] eReg [NE];
	logic [CW-1:0] eCh [NE];
	logic [NE-1:0] conf;
	logic [NE-1:0] fHit;
	logic [IW-1:0] freeIdx;
	logic          haveFree;
	logic          awHeld;
	logic          wHeld;
	logic [7:0]    awQ;
	logic [31:0]   wQ;
	logic [3:0]    sQ;

	// ****************************************
	// Decoding functions
	// ****************************************
	// First matching region wins; no match means cacheable main memory.
	function automatic logic [32:0] lookup(input logic [31:0] a);
		int i;
		lookup = {1'b0, ordering_pkg::ATTR_RST};
		for (i = NR - 1; i >= 0; i--) begin
			if ((a & mask[i]) == base[i]) begin
				lookup = {1'b1, attr[i]};
			end
		end
	endfunction

	function automatic logic [IW-1:0] lookIdx(input logic [31:0] a);
		int i;
		lookIdx = '0;
		for (i = NR - 1; i >= 0; i--) begin
			if ((a & mask[i]) == base[i]) begin
				lookIdx = i[IW-1:0];
			end
		end
	endfunction

	function automatic logic regOk(input logic [7:0] a);
		regOk = (a[7:6] == 2'h0 && a[3:2] != 2'h3) || a[7:2] == ordering_pkg::OFF_STATUS[7:2]
			|| a[7:2] == ordering_pkg::OFF_CTRL[7:2];
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
			input logic [3:0] s);
		int k;
		merge = o;
		for (k = 0; k < 4; k++) begin
			if (s[k]) begin
				merge[8*k+:8] = n[8*k+:8];
			end
		end
	endfunction

	// ****************************************
	// Request classification
	// ****************************************
	wire [32:0]   rLook   = lookup(reqAddr);
	wire [IW-1:0] rIdx    = lookIdx(reqAddr);
	wire [31:0]   rAttr   = rLook[31:0];
	wire          rIo     = rAttr[ordering_pkg::A_IO];
	wire          rStr    = rAttr[ordering_pkg::A_STRONG] & rLook[32];
	wire [CW-1:0] rCh     = rAttr[ordering_pkg::A_CH+:CW];
	wire          rCache  = rAttr[ordering_pkg::A_CACHE] & ~rIo;
	wire          rCoh    = rAttr[ordering_pkg::A_COH];
	wire [32:0]   pLook   = lookup(pfAddr);
	wire          orderAll = ctrl[ordering_pkg::C_ORDALL];
	wire          anySucc = succIoInput | succIoOutput | succMemRead | succMemWrite;

	// Cacheability feeds no term below, so it cannot loosen or tighten order.
	genvar g;
	generate
		for (g = 0; g < NE; g++) begin : gEnt
			wire same  = eAddr[g] == reqAddr[31:2];
			wire bIo   = eIo[g] & rIo;
			wire dom   = eIo[g] == rIo;
			wire acqR  = dom & (eAcq[g] | reqRelease);
			wire memOv = ~eIo[g] & ~rIo & same;
			wire ioOv  = bIo & same;
			wire ioStr = bIo & rStr & eStr[g] & eReg[g] == rIdx;
			wire ioC1  = bIo & (eCh[g] == ordering_pkg::CH_STRICT
				| rCh == ordering_pkg::CH_STRICT);
			wire ioCs  = bIo & eCh[g] == rCh & rCh != ordering_pkg::CH_NONE;
			assign conf[g] = eV[g] & (orderAll | acqR | memOv | ioOv | ioStr | ioC1 | ioCs);
			// Fences hold successors until every predecessor of the kinds selected by the pred bits has completed.
			assign fHit[g] = eV[g] & ((eIo[g] & ~eWr[g] & predIoInput)
				| (eIo[g] & eWr[g] & predIoOutput)
				| (~eIo[g] & ~eWr[g] & predMemRead)
				| (~eIo[g] & eWr[g] & predMemWrite));
		end
	endgenerate

	always_comb begin
		freeIdx  = '0;
		haveFree = 1'b0;
		for (int i = NE - 1; i >= 0; i--) begin
			if (!eV[i]) begin
				freeIdx  = i[IW-1:0];
				haveFree = 1'b1;
			end
		end
	end

	// Waiting on completion is slower than pure ordering but needs no help
	// from the memory system beyond its done pulse.
	wire fenceBlock = anySucc & (|fHit);
	wire outFree    = ~memValid | memReady;
	wire take       = reqValid & reqReady & ~reqFence;
	assign reqReady = reqFence ? ~fenceBlock : (outFree & haveFree & ~(|conf));

	// ****************************************
	// Issue register and outstanding table
	// ****************************************
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			memValid     <= 1'b0;
			memAddr      <= '0;
			memWrite     <= 1'b0;
			memIo        <= 1'b0;
			memCacheable <= 1'b0;
			memCoherent  <= 1'b0;
			memTag       <= '0;
		end else if (take) begin
			memValid     <= 1'b1;
			memAddr      <= reqAddr;
			memWrite     <= reqWrite;
			memIo        <= rIo;
			memCacheable <= rCache;
			memCoherent  <= rCoh;
			memTag       <= freeIdx;
		end else if (memReady) begin
			memValid <= 1'b0;
		end
	end

	generate
		for (g = 0; g < NE; g++) begin : gTab
			always_ff @(posedge core_clk or posedge reset) begin
				if (reset) begin
					eV[g] <= 1'b0;
				end else if (take && freeIdx == g) begin
					eV[g] <= 1'b1;
				end else if (doneValid && doneTag == g) begin
					eV[g] <= 1'b0;
				end
			end
			always_ff @(posedge core_clk or posedge reset) begin
				if (reset) begin
					eAddr[g] <= '0;
					eIo[g]   <= 1'b0;
					eWr[g]   <= 1'b0;
					eAcq[g]  <= 1'b0;
					eStr[g]  <= 1'b0;
					eReg[g]  <= '0;
					eCh[g]   <= '0;
				end else if (take && freeIdx == g) begin
					eAddr[g] <= reqAddr[31:2];
					eIo[g]   <= rIo;
					eWr[g]   <= reqWrite;
					eAcq[g]  <= reqAcquire;
					eStr[g]  <= rStr;
					eReg[g]  <= rIdx;
					eCh[g]   <= rCh;
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pfOk <= 1'b0;
		end else begin
			pfOk <= pLook[ordering_pkg::A_IDEM];
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			stallCnt <= ordering_pkg::STALL_RST;
		end else if (reqValid && !reqReady && stallCnt != 16'hffff) begin
			stallCnt <= stallCnt + 16'h0001;
		end
	end

	// ****************************************
	// Register bus
	// ****************************************
	assign awready = ~awHeld & ~bvalid;
	assign wready  = ~wHeld & ~bvalid;
	assign arready = ~rvalid;
	wire doWrite   = awHeld & wHeld & ~bvalid;
	wire [IW-1:0] wReg = awQ[5:4];

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			awHeld <= 1'b0;
			wHeld  <= 1'b0;
			awQ    <= '0;
			wQ     <= '0;
			sQ     <= '0;
			bvalid <= 1'b0;
			bresp  <= ordering_pkg::RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				awHeld <= 1'b1;
				awQ    <= awaddr;
			end
			if (wvalid && wready) begin
				wHeld <= 1'b1;
				wQ    <= wdata;
				sQ    <= wstrb;
			end
			if (doWrite) begin
				awHeld <= 1'b0;
				wHeld  <= 1'b0;
				bvalid <= 1'b1;
				bresp  <= regOk(awQ) ? ordering_pkg::RESP_OKAY : ordering_pkg::RESP_DECERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	generate
		for (g = 0; g < NR; g++) begin : gReg
			wire hit = doWrite & awQ[7:6] == 2'h0 & wReg == g;
			always_ff @(posedge core_clk or posedge reset) begin
				if (reset) begin
					base[g] <= ordering_pkg::BASE_RST;
					mask[g] <= ordering_pkg::MASK_RST;
					attr[g] <= ordering_pkg::ATTR_RST;
				end else if (hit && awQ[3:2] == ordering_pkg::SUB_BASE) begin
					base[g] <= merge(base[g], wQ, sQ);
				end else if (hit && awQ[3:2] == ordering_pkg::SUB_MASK) begin
					mask[g] <= merge(mask[g], wQ, sQ);
				end else if (hit && awQ[3:2] == ordering_pkg::SUB_ATTR) begin
					attr[g] <= merge(attr[g], wQ, sQ);
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ctrl <= ordering_pkg::CTRL_RST;
		end else if (doWrite && awQ[7:2] == ordering_pkg::OFF_CTRL[7:2]) begin
			ctrl <= merge(ctrl, wQ, sQ) & 32'h0000_0001;
		end
	end

	wire [IW-1:0] aReg = araddr[5:4];
	wire [31:0] status = {stallCnt, 11'h000, memValid, eV};
	wire [31:0] regVal = araddr[3:2] == ordering_pkg::SUB_BASE ? base[aReg]
		: araddr[3:2] == ordering_pkg::SUB_MASK ? mask[aReg] : attr[aReg];
	wire [31:0] rdMux = !regOk(araddr) ? 32'h0000_0000
		: araddr[7:6] == 2'h0 ? regVal
		: araddr[7:2] == ordering_pkg::OFF_CTRL[7:2] ? ctrl : status;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rvalid <= 1'b0;
			rdata  <= '0;
			rresp  <= ordering_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata  <= rdMux;
			rresp  <= regOk(araddr) ? ordering_pkg::RESP_OKAY : ordering_pkg::RESP_DECERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// file: shared/ordering_pkg.sv
// Constants for the access ordering gate: register map, attribute fields,
// reset values and ordering channel codes.
// Assumes a 32-bit AXI4-Lite slave port with an 8-bit byte address.
`default_nettype none
package ordering_pkg;
	localparam int NREG = 4;
	localparam int NENT = 4;
	localparam int IDXW = 2;
	localparam int CHW  = 3;
	// Region registers sit at region * 16 plus 4 times these word offsets.
	localparam logic [1:0] SUB_BASE = 2'h0;
	localparam logic [1:0] SUB_MASK = 2'h1;
	localparam logic [1:0] SUB_ATTR = 2'h2;
	localparam logic [7:0] OFF_STATUS = 8'h40;
	localparam logic [7:0] OFF_CTRL   = 8'h44;
	// Attribute field positions.
	localparam int A_IO     = 0;
	localparam int A_STRONG = 1;
	localparam int A_CACHE  = 2;
	localparam int A_COH    = 3;
	localparam int A_IDEM   = 4;
	localparam int A_CH     = 8;
	// Control and status field positions.
	localparam int C_ORDALL = 0;
	localparam int S_ENT    = 0;
	localparam int S_OUT    = 4;
	localparam int S_STALL  = 16;
	// Values after reset.
	localparam logic [31:0] BASE_RST = 32'h0000_0000;
	localparam logic [31:0] MASK_RST = 32'h0000_0000;
	localparam logic [31:0] ATTR_RST = 32'h0000_001c;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [15:0] STALL_RST = 16'h0000;
	// Ordering channels.
	localparam logic [CHW-1:0] CH_NONE   = 3'h0;
	localparam logic [CHW-1:0] CH_STRICT = 3'h1;
	// Bus responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage
`default_nettype wire

// file: test/ordering_gate_sva.sv
// Assertions on the access ordering gate, bound to its top module.
// Assumes only the top ports; the access waiting on memReady counts as outstanding.
`timescale 1ns/100ps
`default_nettype none
module ordering_gate_sva (
	input wire logic        core_clk, reset, reqValid, reqReady, reqFence,
	input wire logic        predIoInput, predIoOutput, predMemRead, predMemWrite,
	input wire logic        succIoInput, succIoOutput, succMemRead, succMemWrite,
	input wire logic        memValid, memReady, memWrite, memIo, memCacheable,
	input wire logic        doneValid, awvalid, awready, wvalid, wready,
	input wire logic        bvalid, bready, rvalid, rready,
	input wire logic [1:0]  memTag, doneTag, bresp,
	input wire logic [31:0] reqAddr, memAddr, rdata
);
	logic [3:0]  busy, pred;
	logic [1:0]  kind [4];
	logic [29:0] word [4];
	logic        predHit, sameWord, succAny;
	assign pred = {predMemWrite, predMemRead, predIoOutput, predIoInput};
	assign succAny = succIoInput || succIoOutput || succMemRead || succMemWrite;
	always_comb begin
		predHit = memValid && pred[{!memIo, memWrite}];
		sameWord = memValid && memAddr[31:2] == reqAddr[31:2];
		for (int i = 0; i < 4; i++) begin
			predHit = predHit || (busy[i] && pred[{!kind[i][1], kind[i][0]}]);
			sameWord = sameWord || (busy[i] && word[i] == reqAddr[31:2]);
		end
	end
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			busy <= 4'h0;
		end else begin
			if (doneValid) busy[doneTag] <= 1'b0;
			if (memValid && memReady) busy[memTag] <= 1'b1;
		end
	end
	always_ff @(posedge core_clk) begin
		if (memValid && memReady) begin
			kind[memTag] <= {memIo, memWrite};
			word[memTag] <= memAddr[31:2];
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence bothTaken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence fenceAsk;
		reqValid && reqFence && succAny;
	endsequence
	memHold_a: assert property (memValid && !memReady |=>
		memValid && $stable(memAddr) && $stable(memTag)) else $error("memory request dropped");
	ioUncached_a: assert property (memValid && memIo |-> !memCacheable)
		else $error("I/O access marked cacheable");
	fenceGate_a: assert property (fenceAsk |-> reqReady == !predHit)
		else $error("fence gating wrong");
	fenceFree_a: assert property (reqValid && reqFence && !succAny |-> reqReady)
		else $error("fence without successors held");
	wordOrder_a: assert property (reqValid && !reqFence && sameWord |-> !reqReady)
		else $error("overlapping access passed");
	writeResp_a: assert property (bothTaken |-> ##2 bvalid)
		else $error("write response late");
	respHold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	readHold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
endmodule
bind io_memory_access_ordering ordering_gate_sva chk_u (.*);
`default_nettype wire

// file: test/mem_system_model.sv
// Behavioural memory system on the gate's memory side.
// Assumes one clock; completions return in issue order DLY cycles later.
`timescale 1ns/100ps
`default_nettype none
module mem_system_model #(parameter int DLY = 12) (
	input wire logic        core_clk, reset, memValid, slow,
	input wire logic [1:0]  memTag,
	output logic            memReady, doneValid,
	output logic [1:0]      doneTag
);
	// Slow mode keeps memReady low a few cycles, so a request must be held.
	logic [1:0] tags [$];
	int         due [$];
	int         cyc;
	logic [1:0] waitCnt;
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cyc = 0;
			tags.delete();
			due.delete();
			{memReady, doneValid, doneTag, waitCnt} <= '0;
		end else begin
			cyc++;
			waitCnt <= memValid && !memReady ? waitCnt + 2'h1 : 2'h0;
			memReady <= !slow || waitCnt == 2'h2;
			if (memValid && memReady) begin
				tags.push_back(memTag);
				due.push_back(cyc + DLY);
			end
			if (tags.size() > 0 && due[0] <= cyc) begin
				doneValid <= 1'b1;
				doneTag <= tags.pop_front();
				void'(due.pop_front());
			end else begin
				doneValid <= 1'b0;
				doneTag <= ~doneTag;
			end
		end
	end
endmodule
`default_nettype wire

// file: test/io_memory_access_ordering_test.sv
// Testbench for the access ordering gate.
// Assumes the memory model above and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module io_memory_access_ordering_test;
	localparam int DLY = 12;
	localparam logic [3:0] RD = 4'h0, WR = 4'h4, FN = 4'h8;
	localparam logic [31:0] MEM = 32'h80000000, IO0 = 32'h10000000;
	logic        core_clk = 1'b0, reset = 1'b1, slow = 1'b0;
	logic        reqValid, reqReady, reqWrite, reqAcquire, reqRelease, reqFence;
	logic        predIoInput, predIoOutput, predMemRead, predMemWrite;
	logic        succIoInput, succIoOutput, succMemRead, succMemWrite;
	logic        memValid, memReady, memWrite, memIo, memCacheable, memCoherent;
	logic        doneValid, pfOk, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [1:0]  memTag, doneTag, bresp, rresp;
	logic [3:0]  wstrb = 4'hf;
	logic [7:0]  awaddr, araddr;
	logic [31:0] reqAddr, memAddr, pfAddr, wdata, rdata;
	logic [31:0] cfg [12] = '{32'h10000000, 32'hff000000, 32'h1, 32'h20000000, 32'hff000000,
		32'h3, 32'h30000000, 32'hff000000, 32'h105, 32'h40000000, 32'hff000000, 32'h201};
	int          nFail = 0, compares = 0, cyc = 0;
	io_memory_access_ordering dut_u (.*);
	mem_system_model #(.DLY(DLY)) model_u (.*);
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 8000) begin
			nFail++;
			summarize();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			nFail++;
			$display("unexpected at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	task automatic summarize;
		$display("compares %0d, mismatches %0d", compares, nFail);
		if (nFail == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic send(input logic [31:0] a, input logic [3:0] k, input logic [7:0] ps,
		input logic e);
		int n;
		@(posedge core_clk);
		reqValid <= 1'b1;
		reqAddr <= a;
		{reqFence, reqWrite, reqAcquire, reqRelease} <= k;
		{predIoInput, predIoOutput, predMemRead, predMemWrite} <= ps[7:4];
		{succIoInput, succIoOutput, succMemRead, succMemWrite} <= ps[3:0];
		#1 chk({31'h0, reqReady}, {31'h0, e});
		n = 0;
		while (reqReady !== 1'b1 && n < 200) begin
			@(posedge core_clk);
			#1 n++;
		end
		@(posedge core_clk);
		reqValid <= 1'b0;
	endtask
	// The second access is offered while the first is still outstanding.
	task automatic pair(input logic [31:0] a1, input logic [3:0] k1, input logic [31:0] a2,
		input logic [3:0] k2, input logic [7:0] ps, input logic e);
		send(a1, k1, 8'h0, 1'b1);
		send(a2, k2, ps, e);
		repeat (DLY + 8) @(posedge core_clk);
	endtask
	task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e);
		int n;
		logic ta, tw, tr, fin;
		logic [31:0] rd;
		logic [1:0] rs;
		@(posedge core_clk);
		{awaddr, araddr, wdata} <= {a, a, d};
		{awvalid, wvalid, bready} <= {3{wr}};
		{arvalid, rready} <= {2{!wr}};
		n = 0;
		do begin
			#1;
			{ta, tw, tr} = {awvalid && awready, wvalid && wready, arvalid && arready};
			{fin, rd, rs} = wr ? {bvalid, rdata, bresp} : {rvalid, rdata, rresp};
			@(posedge core_clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tr) arvalid <= 1'b0;
			n++;
		end while (!fin && n < 100);
		{bready, rready} <= 2'h0;
		if (!wr) chk(rd, d);
		chk({30'h0, rs}, {30'h0, e});
	endtask
	initial begin
		{reqValid, reqWrite, reqAcquire, reqRelease, reqFence, reqAddr, pfAddr} = '0;
		{predIoInput, predIoOutput, predMemRead, predMemWrite} = '0;
		{succIoInput, succIoOutput, succMemRead, succMemWrite} = '0;
		{awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		axi(0, 8'h40, 32'h0, 2'h0);
		axi(0, 8'h08, 32'h1c, 2'h0);
		axi(0, 8'h04, 32'h0, 2'h0);
		axi(0, 8'h48, 32'h0, 2'h3);
		axi(1, 8'h4c, 32'h1, 2'h3);
		axi(1, 8'h40, 32'h1, 2'h0);
		for (int i = 0; i < 12; i++) axi(1, 8'(16 * (i / 3) + 4 * (i % 3)), cfg[i], 2'h0);
		axi(0, 8'h28, 32'h105, 2'h0);
		pair(IO0, WR, IO0 + 2, RD, 8'h0, 0);
		pair(IO0, WR, IO0 + 16, WR, 8'h0, 1);
		pair(32'h20000000, WR, 32'h20000100, RD, 8'h0, 0);
		pair(32'h30000000, WR, IO0 + 64, RD, 8'h0, 0);
		pair(32'h40000000, WR, 32'h40000100, WR, 8'h0, 0);
		pair(32'h40000000, WR, IO0, WR, 8'h0, 1);
		pair(MEM, 4'h6, IO0, RD, 8'h0, 1);
		pair(MEM, 4'h2, MEM + 64, RD, 8'h0, 0);
		pair(IO0, WR, IO0 + 64, 4'h5, 8'h0, 0);
		pair(MEM, WR, MEM + 64, WR, 8'h0, 1);
		pair(MEM, WR, 32'h0, FN, 8'h14, 0);
		pair(MEM, WR, 32'h0, FN, 8'h44, 1);
		pair(MEM, WR, 32'h0, FN, 8'h10, 1);
		pair(IO0, RD, 32'h0, FN, 8'h82, 0);
		axi(1, 8'h44, 32'h1, 2'h0);
		pair(MEM, WR, MEM + 64, WR, 8'h0, 0);
		axi(1, 8'h44, 32'h0, 2'h0);
		slow <= 1'b1;
		pair(MEM, WR, MEM + 64, WR, 8'h0, 0);
		slow <= 1'b0;
		send(IO0, RD, 8'h0, 1'b1);
		#1 chk(memAddr, IO0);
		chk({29'h0, memIo, memCacheable, memCoherent}, 32'h4);
		repeat (DLY + 8) @(posedge core_clk);
		send(MEM, RD, 8'h0, 1'b1);
		#1 chk({29'h0, memIo, memCacheable, memCoherent}, 32'h3);
		repeat (DLY + 8) @(posedge core_clk);
		pfAddr <= IO0;
		@(posedge core_clk);
		#1 chk({31'h0, pfOk}, 32'h0);
		@(posedge core_clk);
		pfAddr <= MEM;
		@(posedge core_clk);
		#1 chk({31'h0, pfOk}, 32'h1);
		summarize();
	end
endmodule
`default_nettype wire
